// ### usbev_engine_model.sv
// Stand-in for the USB engine: event strobes, line levels and a transfer status queue.
`timescale 1ns/1ns
module usbev_engine_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench requests and queue step
  input wire logic [11:0] eng_req,
  input wire logic fifo_advance,
  // Engine outputs
  output usbev_pkg::usbev_evt_s usb_evt,
  output logic [7:0] xfer_status
);
  import usbev_pkg::*;
  logic idx_q;
  assign xfer_status = idx_q ? 8'hB2 : 8'hA1;
  // Requests pass through a flop so every strobe leaves on a clock edge, as from real logic.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      usb_evt <= '0;
      idx_q <= 1'b0;
    end else begin
      usb_evt <= usbev_evt_s'(eng_req);
      if (fifo_advance) begin
        idx_q <= 1'b1;
      end
    end
  end
endmodule

// ### usbev_pkg.sv
// Package with register map, field positions and timing counts of the USB event flag block.
package usbev_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [11:0] OFS_FLAGS = 12'h000;
  localparam logic [11:0] OFS_ENABLES = 12'h004;
  localparam logic [11:0] OFS_ERR_ENABLES = 12'h008;
  localparam logic [11:0] OFS_CONTROL = 12'h00C;
  localparam logic [11:0] OFS_XFER_STATUS = 12'h010;

  // Bit positions shared by the flag and enable registers, and the host enable bit of the control register.
  localparam int BIT_BUS_RESET = 0;
  localparam int BIT_SUM_ERROR = 1;
  localparam int BIT_SOF = 2;
  localparam int BIT_TOKEN_DONE = 3;
  localparam int BIT_IDLE = 4;
  localparam int BIT_RESUME = 5;
  localparam int BIT_ATTACH = 6;
  localparam int BIT_STALL = 7;
  localparam int BIT_HOST_EN = 0;
  localparam int FLAG_W = 8;

  // Reset values.
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] ENABLES_RST = 8'h00;
  localparam logic [7:0] ERR_EN_RST = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // Timing: clock period, bus quiet time and idle time.
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_QUIET_NS = 2500;
  localparam int T_IDLE_MS = 3;
  localparam int QUIET_CYC = (T_QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int IDLE_CYC = (T_IDLE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int QUIET_W = 10;
  localparam int IDLE_W = 20;

  // Bus-side event strobes and line levels from the USB engine.
  typedef struct packed {
    logic stall_rx;
    logic stall_tx;
    logic attach_seen;
    logic token_done;
    logic sof_rx;
    logic sof_threshold;
    logic usb_reset;
    logic detach_seen;
    logic bus_activity;
    logic line_se0;
    logic line_k;
    logic line_idle;
  } usbev_evt_s;

  // APB request signals.
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } usbev_apb_req_s;

  // Whole state of the block.
  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] enables;
    logic [7:0] err_en;
    logic host_en;
    logic [QUIET_W-1:0] quiet_cnt;
    logic [QUIET_W-1:0] k_cnt;
    logic [IDLE_W-1:0] idle_cnt;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic fifo_advance;
  } usbev_state_s;

endpackage

// ### usbev_top.sv
// USB event flags, enables and combined interrupt behind an APB slave.
//
// Function
// RL1 - Host mode: received STALL sets bit 7.
// RL2 - Device mode: transmitted STALL sets bit 7.
// RL3 - Peripheral attach detected sets bit 6.
// RL4 - Attach valid: host on, 2.5us quiet, no SE0.
// RL5 - K-state held 2.5us sets bit 5.
// RL6 - Software keeps resume disabled outside suspend.
// RL7 - Idle held 3 ms sets bit 4.
// RL8 - Token finished sets bit 3, status readable.
// RL9 - Clearing token-done advances transfer status FIFO.
// RL10 - SOF received or threshold reached sets bit 2.
// RL11 - Only enabled error conditions set bit 1.
// RL12 - Device mode: valid USB reset sets bit 0.
// RL13 - Host mode: detach sets bit 0.
// RL14 - Enable bits match flags, reset to zero.
// RL15 - Bits 31 to 8 read as zero.
// RL16 - Enable bit 0 gates reset or detach.
// RL17 - Flags write-one-clear; summary error read-only.
// RL18 - Software sets error enable for error interrupts.
// RL19 - Interrupt high while enabled flag set.
`timescale 1ns/1ns
module usbev_top #(
  parameter int IDLE_CYCLES = usbev_pkg::IDLE_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire usbev_pkg::usbev_apb_req_s apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // USB engine events and line state
  input wire usbev_pkg::usbev_evt_s usb_evt,
  input wire logic [7:0] error_flags,
  input wire logic [7:0] xfer_status,
  // Interrupt and FIFO control
  output logic combined_usb_interrupt,
  output logic stat_fifo_advance
);
  import usbev_pkg::*;

  localparam logic [QUIET_W-1:0] QUIET_MAX = QUIET_W'(QUIET_CYC);
  localparam logic [IDLE_W-1:0] IDLE_MAX = IDLE_W'(IDLE_CYCLES);

  usbev_state_s st_q;
  usbev_state_s st_d;

  logic setup_ph;
  logic access_ph;
  logic wr_lane0;
  logic [7:0] set_vec;
  logic [7:0] clr_vec;
  logic [31:0] rd_word;
  logic rd_err;
  logic sum_err;

  always_comb begin
    st_d = st_q;
    setup_ph = apb_req.psel && !apb_req.penable;
    access_ph = apb_req.psel && apb_req.penable && st_q.pready;
    wr_lane0 = access_ph && apb_req.pwrite && apb_req.pstrb[0];
    set_vec = 8'h00;
    clr_vec = 8'h00;
    rd_word = WORD_ZERO;
    rd_err = 1'b0;

    // Bus quiet timer: restarts on any activity, saturates at the quiet time.
    if (usb_evt.bus_activity) begin
      st_d.quiet_cnt = '0;
    end else if (st_q.quiet_cnt != QUIET_MAX) begin
      st_d.quiet_cnt = st_q.quiet_cnt + QUIET_W'(1);
    end

    // K-state persistence timer.
    if (!usb_evt.line_k) begin
      st_d.k_cnt = '0;
    end else if (st_q.k_cnt != QUIET_MAX) begin
      st_d.k_cnt = st_q.k_cnt + QUIET_W'(1);
    end

    // Idle persistence timer; a long count so simulation may shorten it.
    if (!usb_evt.line_idle) begin
      st_d.idle_cnt = '0;
    end else if (st_q.idle_cnt != IDLE_MAX) begin
      st_d.idle_cnt = st_q.idle_cnt + IDLE_W'(1);
    end

    // Event sources, steered by the host operation enable.
    if (st_q.host_en) begin
      set_vec[BIT_STALL] = usb_evt.stall_rx; // RL1
      set_vec[BIT_SOF] = usb_evt.sof_threshold; // RL10
      set_vec[BIT_BUS_RESET] = usb_evt.detach_seen; // RL13
    end else begin
      set_vec[BIT_STALL] = usb_evt.stall_tx; // RL2
      set_vec[BIT_SOF] = usb_evt.sof_rx; // RL10
      set_vec[BIT_BUS_RESET] = usb_evt.usb_reset; // RL12
    end
    // Attach only counts once the bus has been quiet and not in SE0.
    set_vec[BIT_ATTACH] = usb_evt.attach_seen && st_q.host_en // RL3
      && (st_q.quiet_cnt == QUIET_MAX) && !usb_evt.line_se0; // RL4
    // One pulse as the K count reaches the threshold; saturation stops repeats.
    set_vec[BIT_RESUME] = usb_evt.line_k && (st_q.k_cnt == QUIET_MAX - QUIET_W'(1)); // RL5
    set_vec[BIT_IDLE] = usb_evt.line_idle && (st_q.idle_cnt == IDLE_MAX - IDLE_W'(1)); // RL7
    set_vec[BIT_TOKEN_DONE] = usb_evt.token_done; // RL8

    // Summary error follows the enabled error conditions and cannot be cleared.
    sum_err = |(error_flags & st_q.err_en); // RL11

    // Register write side.
    if (wr_lane0 && apb_req.paddr == OFS_FLAGS) begin
      clr_vec = apb_req.pwdata[7:0]; // RL17
      clr_vec[BIT_SUM_ERROR] = 1'b0; // RL17
    end else if (wr_lane0 && apb_req.paddr == OFS_ENABLES) begin
      st_d.enables = apb_req.pwdata[7:0]; // RL14
    end else if (wr_lane0 && apb_req.paddr == OFS_ERR_ENABLES) begin
      st_d.err_en = apb_req.pwdata[7:0];
    end else if (wr_lane0 && apb_req.paddr == OFS_CONTROL) begin
      st_d.host_en = apb_req.pwdata[BIT_HOST_EN];
    end

    // A set in the same cycle as its clear keeps the flag set.
    for (int i = 0; i < FLAG_W; i++) begin
      st_d.flags[i] = (st_q.flags[i] && !clr_vec[i]) || set_vec[i]; // RL17
    end
    st_d.flags[BIT_SUM_ERROR] = sum_err; // RL11

    // Popping the status FIFO as software acknowledges the completed token.
    st_d.fifo_advance = clr_vec[BIT_TOKEN_DONE] && st_q.flags[BIT_TOKEN_DONE]; // RL9

    // Interrupt follows the next flag and enable values so it tracks them exactly.
    st_d.irq = |(st_d.flags & st_d.enables); // RL19 RL16

    // Read side: upper bits of every register read as zero.
    if (apb_req.paddr == OFS_FLAGS) begin
      rd_word = {24'h000000, st_q.flags}; // RL15
    end else if (apb_req.paddr == OFS_ENABLES) begin
      rd_word = {24'h000000, st_q.enables}; // RL15
    end else if (apb_req.paddr == OFS_ERR_ENABLES) begin
      rd_word = {24'h000000, st_q.err_en};
    end else if (apb_req.paddr == OFS_CONTROL) begin
      rd_word = {31'h00000000, st_q.host_en};
    end else if (apb_req.paddr == OFS_XFER_STATUS) begin
      rd_word = {24'h000000, xfer_status}; // RL8
    end else begin
      rd_err = 1'b1;
    end

    // One wait-free answer: ready rises in the cycle after setup.
    if (setup_ph) begin
      st_d.pready = 1'b1;
      st_d.pslverr = rd_err;
      st_d.prdata = apb_req.pwrite ? WORD_ZERO : rd_word;
    end else begin
      st_d.pready = 1'b0;
      st_d.pslverr = 1'b0;
      st_d.prdata = WORD_ZERO;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q.flags <= FLAGS_RST;
      st_q.enables <= ENABLES_RST; // RL14
      st_q.err_en <= ERR_EN_RST;
      st_q.host_en <= 1'b0;
      st_q.quiet_cnt <= '0;
      st_q.k_cnt <= '0;
      st_q.idle_cnt <= '0;
      st_q.prdata <= WORD_ZERO;
      st_q.pready <= 1'b0;
      st_q.pslverr <= 1'b0;
      st_q.irq <= 1'b0;
      st_q.fifo_advance <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign combined_usb_interrupt = st_q.irq;
  assign stat_fifo_advance = st_q.fifo_advance;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_stall_host_set: assert property ( // RL1
    st_q.host_en && usb_evt.stall_rx |=> st_q.flags[BIT_STALL])
    else $error("stall flag not set by received stall");

  chk_stall_dev_set: assert property ( // RL2
    !st_q.host_en && usb_evt.stall_tx |=> st_q.flags[BIT_STALL])
    else $error("stall flag not set by sent stall");

  chk_attach_gate: assert property ( // RL4
    $rose(st_q.flags[BIT_ATTACH]) |-> $past(st_q.host_en) && !$past(usb_evt.line_se0)
      && $past(st_q.quiet_cnt) == QUIET_MAX)
    else $error("attach flag set outside valid conditions");

  chk_resume_time: assert property ( // RL5
    $rose(st_q.flags[BIT_RESUME]) |-> $past(st_q.k_cnt) == QUIET_MAX - QUIET_W'(1))
    else $error("resume flag set before K time");

  chk_idle_time: assert property ( // RL7
    $rose(st_q.flags[BIT_IDLE]) |-> $past(st_q.idle_cnt) == IDLE_MAX - IDLE_W'(1))
    else $error("idle flag set before idle time");

  chk_token_set: assert property ( // RL8
    usb_evt.token_done |=> st_q.flags[BIT_TOKEN_DONE])
    else $error("token done flag not set");

  chk_fifo_pop: assert property ( // RL9
    $fell(st_q.flags[BIT_TOKEN_DONE]) |-> st_q.fifo_advance)
    else $error("token done cleared without fifo advance");

  chk_sum_err: assert property ( // RL11
    ##1 st_q.flags[BIT_SUM_ERROR] == |($past(error_flags) & $past(st_q.err_en)))
    else $error("summary error does not follow enabled errors");

  chk_bit0_mode: assert property ( // RL12
    st_q.host_en && usb_evt.usb_reset && !usb_evt.detach_seen && !st_q.flags[0]
      && !wr_lane0 |=> !st_q.flags[BIT_BUS_RESET])
    else $error("bus reset set bit 0 in host mode");

  chk_upper_zero: assert property ( // RL15
    st_q.pready && !st_q.pslverr && $past(apb_req.paddr) != OFS_CONTROL
      |-> st_q.prdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");

  chk_irq_level: assert property ( // RL19
    combined_usb_interrupt == |(st_q.flags & st_q.enables))
    else $error("interrupt does not match enabled flags");

  chk_w1c_clear: assert property ( // RL17
    wr_lane0 && apb_req.paddr == OFS_FLAGS && apb_req.pwdata[BIT_STALL]
      && !set_vec[BIT_STALL] |=> !st_q.flags[BIT_STALL])
    else $error("write one did not clear stall flag");

  cov_attach: cover property (st_q.host_en ##1 $rose(st_q.flags[BIT_ATTACH]));
  cov_token_pop: cover property ($rose(st_q.fifo_advance));
  cov_irq: cover property ($rose(combined_usb_interrupt) ##[1:20] $fell(combined_usb_interrupt));
  cov_set_clear: cover property (wr_lane0 && |(clr_vec & set_vec));

endmodule

// ### usbev_top_tb.sv
// Self-checking bench for the USB event flag block.
`timescale 1ns/1ns
module usbev_top_tb;
  import usbev_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  usbev_apb_req_s apb_req = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic adv;
  logic [11:0] eng = 12'h000;
  usbev_evt_s usb_evt;
  logic [7:0] error_flags = 8'h00;
  logic [7:0] xfer_status;
  logic [31:0] rdat;
  logic rerr;
  int fail_count = 0;
  int checks_done = 0;
  usbev_top #(.IDLE_CYCLES(40)) usbev_top_inst (.pclk(pclk), .presetn(presetn),
    .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .usb_evt(usb_evt), .error_flags(error_flags), .xfer_status(xfer_status),
    .combined_usb_interrupt(irq), .stat_fifo_advance(adv));
  usbev_engine_model usbev_engine_model_inst (.pclk(pclk), .presetn(presetn),
    .eng_req(eng), .fifo_advance(adv), .usb_evt(usb_evt), .xfer_status(xfer_status));

  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d, pstrb: 4'hF};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    // Ready is looked at between edges, so it is never raced against the edge that launches it.
    do begin
      @(negedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fail_count++;
    end
    rdat = prdata;
    rerr = pslverr;
    @(posedge pclk);
    apb_req <= '0;
    @(negedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdat, exp);
  endtask
  // Bit order of eng: stall_rx, stall_tx, attach, token, sof_rx, sof_thr, reset, detach, levels.
  task automatic pulse(input logic [11:0] m);
    @(posedge pclk);
    eng <= eng | m;
    @(posedge pclk);
    eng <= eng & ~m;
    repeat (2) @(posedge pclk);
  endtask

  task automatic t_regs;
    rd(OFS_FLAGS, WORD_ZERO);
    rd(OFS_ENABLES, WORD_ZERO);
    wr(OFS_ENABLES, 32'hFFFF_FFFF);
    rd(OFS_ENABLES, 32'h0000_00FF);
    rd(12'h020, WORD_ZERO);
    chk(rerr, 1'b1);
  endtask
  task automatic t_device;
    pulse(12'h400);
    pulse(12'h080);
    pulse(12'h020);
    pulse(12'h100);
    // Host-only strobes must not land while in device mode.
    pulse(12'h850);
    rd(OFS_FLAGS, 32'h0000_008D);
    chk(irq, 1'b1);
    rd(OFS_XFER_STATUS, 32'h0000_00A1);
    wr(OFS_FLAGS, 32'h0000_0008);
    // The advance pulse and the queue step each take one edge before the new entry shows.
    repeat (2) @(posedge pclk);
    rd(OFS_XFER_STATUS, 32'h0000_00B2);
    wr(OFS_ENABLES, 32'h0000_0001);
    chk(irq, 1'b1);
    wr(OFS_FLAGS, 32'h0000_0001);
    rd(OFS_FLAGS, 32'h0000_0084);
    chk(irq, 1'b0);
    wr(OFS_FLAGS, 32'h0000_00FF);
    rd(OFS_FLAGS, WORD_ZERO);
  endtask
  task automatic t_err;
    @(posedge pclk);
    error_flags <= 8'h05;
    rd(OFS_FLAGS, WORD_ZERO);
    wr(OFS_ERR_ENABLES, 32'h0000_0004);
    wr(OFS_FLAGS, 32'h0000_0002);
    rd(OFS_FLAGS, 32'h0000_0002);
    wr(OFS_ENABLES, 32'h0000_0002);
    chk(irq, 1'b1);
    @(posedge pclk);
    error_flags <= 8'h00;
    rd(OFS_FLAGS, WORD_ZERO);
  endtask
  task automatic t_host;
    wr(OFS_CONTROL, 32'h0000_0001);
    pulse(12'h4A0);
    pulse(12'h800);
    pulse(12'h040);
    pulse(12'h010);
    rd(OFS_FLAGS, 32'h0000_0085);
    wr(OFS_FLAGS, 32'h0000_00FF);
    @(posedge pclk);
    eng <= 12'h008;
    @(posedge pclk);
    eng <= 12'h000;
    pulse(12'h200);
    rd(OFS_FLAGS, WORD_ZERO);
    repeat (700) @(posedge pclk);
    eng <= 12'h004;
    pulse(12'h200);
    rd(OFS_FLAGS, WORD_ZERO);
    @(posedge pclk);
    eng <= 12'h000;
    pulse(12'h200);
    rd(OFS_FLAGS, 32'h0000_0040);
    wr(OFS_FLAGS, 32'h0000_00FF);
  endtask
  task automatic t_lines;
    wr(OFS_ENABLES, 32'h0000_0010);
    @(posedge pclk);
    eng <= 12'h002;
    repeat (590) @(posedge pclk);
    rd(OFS_FLAGS, WORD_ZERO);
    repeat (40) @(posedge pclk);
    rd(OFS_FLAGS, 32'h0000_0020);
    chk(irq, 1'b0);
    @(posedge pclk);
    eng <= 12'h001;
    repeat (25) @(posedge pclk);
    rd(OFS_FLAGS, 32'h0000_0020);
    repeat (30) @(posedge pclk);
    rd(OFS_FLAGS, 32'h0000_0030);
    chk(irq, 1'b1);
  endtask

  initial begin
    forever #2 pclk = ~pclk;
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_device;
    t_err;
    t_host;
    t_lines;
    give_verdict;
  end
  // A hang past more than ten times the expected run length ends the test as failed.
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    give_verdict;
  end
endmodule
